// *** src/srh_pkg.sv ***
// Purpose: Constants shared by the static memory host controller.
// Assumes: 40 MHz system clock, fastest speed grade by default.
// Notes: Times are in ns; cycle counts are derived from them.
package srh_pkg;
	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int ADDR_W = 20;
	localparam int DATA_W = 4;
	localparam int CLK_PERIOD_NS = 25;
	// ----------------------------------------
	// Device timing, fastest grade
	// ----------------------------------------
	localparam int T_WRITE_PULSE_NS = 12;
	localparam int T_DATA_SETUP_NS = 8;
	localparam int T_ADDR_ACCESS_NS = 17;
	localparam int T_RELEASE_NS = 7;
	// Least times round up, never below one cycle
	localparam int WP_CYC = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DS_CYC = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_CYC = (T_ADDR_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(T_ADDR_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REL_CYC = (T_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(T_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;
	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		SRH_IDLE = 3'h0,
		SRH_RSEL = 3'h1,
		SRH_RDONE = 3'h3,
		SRH_WSETUP = 3'h4,
		SRH_WPULSE = 3'h5,
		SRH_WEND = 3'h7,
		SRH_TURN = 3'h2
	} srh_state_e;
endpackage

// *** src/srh_sync3.sv ***
// Purpose: Three-stage input synchroniser for the data pins.
// Assumes: Inputs are asynchronous to clk.
// Notes: Output changes once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module srh_sync3 #(
	parameter int W = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end
		else
		begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge clk or negedge nrst)
			begin
				if (!nrst)
					dout[i] <= 1'b0;
				else if (s2_q[i] == s3_q[i])
					dout[i] <= s3_q[i];
			end
		end
	endgenerate
endmodule
`default_nettype wire

// *** src/srh_ctrl.sv ***
// Purpose: Host controller that sequences reads and writes to a 1M x 4 static memory.
// Assumes: Memory strobes are active low, pins driven from flip-flops at 40 MHz.
// Notes: One access at a time; req_ready is high only in the idle state.
// Functional notes
// - Write strobe stays high for the whole read cycle.
// - Host releases data lines while memory read outputs are enabled.
// - Address is stable before the write starts and valid 12 ns before its end.
// - Write strobe and select stay low at least the write pulse time.
// - Write data valid 8 ns before write end, held zero after.
// - Address does not change until the write has ended.
`timescale 1ns/10ps
`default_nettype none
module srh_ctrl #(
	parameter int ADDR_W = srh_pkg::ADDR_W,
	parameter int DATA_W = srh_pkg::DATA_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// User request
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	output logic req_ready,
	// User read answer
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	// Memory pins
	output logic [ADDR_W-1:0] word_address,
	output logic sel_n,
	output logic wstrobe_n,
	output logic ogate_n,
	input wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0] data_out,
	output logic data_oe_n
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	srh_pkg::srh_state_e state_q;
	logic [srh_pkg::CNT_W-1:0] cnt_q;
	logic [DATA_W-1:0] data_sync;

	localparam logic [srh_pkg::CNT_W-1:0] WP_N = srh_pkg::CNT_W'(srh_pkg::WP_CYC);
	localparam logic [srh_pkg::CNT_W-1:0] DS_N = srh_pkg::CNT_W'(srh_pkg::DS_CYC);
	// Pins reach data_sync through four flops; the first samples at the end of the access cycle, so the wait adds three
	localparam logic [srh_pkg::CNT_W-1:0] RD_N = srh_pkg::CNT_W'(srh_pkg::RD_CYC + 3);
	localparam logic [srh_pkg::CNT_W-1:0] REL_N = srh_pkg::CNT_W'(srh_pkg::REL_CYC);

	assign req_ready = (state_q == srh_pkg::SRH_IDLE);

	// ----------------------------------------
	// Access phases
	// ----------------------------------------
	logic rd_take;
	logic wr_take;
	logic wr_low;

	// A request is taken only in idle, so these decode the take edge
	assign rd_take = (state_q == srh_pkg::SRH_IDLE) && req_valid && !req_write;
	assign wr_take = (state_q == srh_pkg::SRH_IDLE) && req_valid && req_write;
	// Strobe low span; select shares it so neither edge of the write depends on
	// which of the two pins moves first at the memory
	assign wr_low = (state_q == srh_pkg::SRH_WSETUP) ||
		((state_q == srh_pkg::SRH_WPULSE) && (cnt_q > srh_pkg::CNT_W'(1)));

	srh_sync3 #(
		.W(DATA_W)
	) u_sync (
		.clk(clk),
		.nrst(nrst),
		.din(data_in),
		.dout(data_sync)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// No refresh state exists: the memory is static
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q <= srh_pkg::SRH_IDLE;
			cnt_q <= '0;
		end
		else
		begin
			case (state_q)
				srh_pkg::SRH_IDLE:
				begin
					if (req_valid)
					begin
						state_q <= req_write ? srh_pkg::SRH_WSETUP : srh_pkg::SRH_RSEL;
						cnt_q <= req_write ? srh_pkg::CNT_W'(1) : RD_N;
					end
				end
				srh_pkg::SRH_RSEL:
				begin
					// Wait covers address access and gate access plus sampling
					if (cnt_q <= srh_pkg::CNT_W'(1))
						state_q <= srh_pkg::SRH_RDONE;
					else
						cnt_q <= cnt_q - srh_pkg::CNT_W'(1);
				end
				srh_pkg::SRH_RDONE:
				begin
					state_q <= srh_pkg::SRH_TURN;
					cnt_q <= REL_N;
				end
				srh_pkg::SRH_WSETUP:
				begin
					// Address and data settle one full cycle before strobe falls
					state_q <= srh_pkg::SRH_WPULSE;
					cnt_q <= (WP_N > DS_N) ? WP_N : DS_N;
				end
				srh_pkg::SRH_WPULSE:
				begin
					if (cnt_q <= srh_pkg::CNT_W'(1))
						state_q <= srh_pkg::SRH_WEND;
					else
						cnt_q <= cnt_q - srh_pkg::CNT_W'(1);
				end
				srh_pkg::SRH_WEND:
				begin
					state_q <= srh_pkg::SRH_TURN;
					cnt_q <= REL_N;
				end
				srh_pkg::SRH_TURN:
				begin
					// Bus gap so the memory has fully released before the next access
					if (cnt_q <= srh_pkg::CNT_W'(1))
						state_q <= srh_pkg::SRH_IDLE;
					else
						cnt_q <= cnt_q - srh_pkg::CNT_W'(1);
				end
				default:
				begin
					state_q <= srh_pkg::SRH_IDLE;
					cnt_q <= '0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Address and write data
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			word_address <= '0;
			data_out <= '0;
		end
		else if (state_q == srh_pkg::SRH_IDLE && req_valid)
		begin
			// Latched once per access, so it stays put until the write ends
			word_address <= req_addr;
			data_out <= req_wdata;
		end
	end

	// ----------------------------------------
	// Strobes
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sel_n <= 1'b1;
			wstrobe_n <= 1'b1;
			ogate_n <= 1'b1;
			data_oe_n <= 1'b1;
		end
		else
		begin
			// In writes select and strobe fall together and rise together: write is the overlap
			sel_n <= !(wr_low || rd_take || state_q == srh_pkg::SRH_RSEL);
			wstrobe_n <= !wr_low;
			// Gate stays high through writes, so memory never drives then
			ogate_n <= !(rd_take || state_q == srh_pkg::SRH_RSEL);
			// Host drives data only during writes, never while gate is low
			// It stays on one cycle past the strobe rise, which gives the data hold
			data_oe_n <= !(wr_take || state_q == srh_pkg::SRH_WSETUP ||
				state_q == srh_pkg::SRH_WPULSE);
		end
	end

	// ----------------------------------------
	// Read answer
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
		end
		else
		begin
			// The sync delay is inside the access wait, so data_sync has settled here
			rsp_valid <= (state_q == srh_pkg::SRH_RDONE);
			if (state_q == srh_pkg::SRH_RDONE)
				rsp_rdata <= data_sync;
		end
	end
endmodule
`default_nettype wire

// *** tb/srh_ctrl_sva.sv ***
// Purpose: Pin sequencing checks for the static memory host controller.
// Assumes: One clock; the bind below attaches it to every controller.
// Notes: Select and strobe move together in writes by design choice.
`timescale 1ns/10ps
`default_nettype none
module srh_ctrl_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Watched ports
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic [srh_pkg::ADDR_W-1:0] word_address,
	input wire logic sel_n,
	input wire logic wstrobe_n,
	input wire logic ogate_n,
	input wire logic data_oe_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	rd_strobe_high_a: assert property (!ogate_n |-> wstrobe_n) else $error("strobe low in read");
	no_contention_a: assert property (!sel_n && !ogate_n |-> data_oe_n) else $error("bus contention");
	write_pair_a: assert property ($fell(wstrobe_n) |-> $fell(sel_n)) else $error("strobe without select");
	pulse_len_a: assert property ($fell(wstrobe_n) |=> $rose(wstrobe_n) && $rose(sel_n)) else $error("bad pulse");
	data_setup_a: assert property ($fell(wstrobe_n) |-> !data_oe_n && $past(!data_oe_n)) else $error("data late");
	addr_setup_a: assert property ($fell(wstrobe_n) |-> $stable(word_address)) else $error("address moved");
	addr_hold_a: assert property ($rose(wstrobe_n) |-> $stable(word_address)) else $error("address early");
	read_answer_a: assert property (req_valid && req_ready && !req_write |-> ##[5:8] rsp_valid) else $error("no data");
endmodule
bind srh_ctrl srh_ctrl_chk u_chk (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req_write(req_write),
	.req_ready(req_ready), .rsp_valid(rsp_valid), .word_address(word_address), .sel_n(sel_n),
	.wstrobe_n(wstrobe_n), .ogate_n(ogate_n), .data_oe_n(data_oe_n));
`default_nettype wire

// *** tb/srh_mem_model.sv ***
// Purpose: Behavioural 1M x 4 static memory on the controller pins.
// Assumes: Host drive wins the data wire while data_oe_n is low.
// Notes: Undriven wire shows the inverse of its last value.
`timescale 1ns/10ps
`default_nettype none
module srh_mem_model (
	// Host pins
	input wire logic [19:0] word_address,
	input wire logic sel_n,
	input wire logic wstrobe_n,
	input wire logic ogate_n,
	input wire logic [3:0] data_out,
	input wire logic data_oe_n,
	// Resolved data wire
	output logic [3:0] data_in
);
	logic [3:0] mem [0:1048575];
	logic [3:0] wbuf;
	logic [3:0] last = 4'h0;
	wire wr = !sel_n && !wstrobe_n;
	wire rd = !sel_n && wstrobe_n && !ogate_n;
	wire rd_late;
	// Slow turn-on, instant release
	assign #3 rd_late = rd;
	wire drv = rd && rd_late;
	always @* if (wr && !data_oe_n) wbuf = data_out;
	always @(negedge wr) mem[word_address] = wbuf;
	always @(negedge drv) last = mem[word_address];
	always @(posedge data_oe_n) last = data_out;
	assign data_in = !data_oe_n ? data_out : drv ? mem[word_address] : ~last;
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the static memory host controller.
// Assumes: Inputs change at the falling edge.
// Notes: Rows are write/address/data; reads expect the data field.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk = 1'h0, nrst = 1'h0, req_valid = 1'h0, req_write = 1'h0;
	logic [19:0] req_addr = 20'h00000, word_address;
	logic [3:0] req_wdata = 4'h0, rsp_rdata, data_in, data_out;
	logic req_ready, rsp_valid, sel_n, wstrobe_n, ogate_n, data_oe_n;
	int mismatches = 0, tests_run = 0;
	logic [24:0] rows [0:7] = '{{1'h1, 20'h00000, 4'hA}, {1'h1, 20'hFFFFF, 4'h5}, {1'h1, 20'h12345, 4'hF},
		{1'h0, 20'hFFFFF, 4'h5}, {1'h0, 20'h00000, 4'hA}, {1'h0, 20'h12345, 4'hF},
		{1'h1, 20'h00000, 4'h0}, {1'h0, 20'h00000, 4'h0}};
	srh_ctrl u_dut (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.word_address(word_address), .sel_n(sel_n), .wstrobe_n(wstrobe_n), .ogate_n(ogate_n),
		.data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));
	srh_mem_model u_mem (.word_address(word_address), .sel_n(sel_n), .wstrobe_n(wstrobe_n), .ogate_n(ogate_n),
		.data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in));
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	task chk(input string n, input logic [3:0] e, input logic [3:0] g);
		tests_run++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task conclude;
		$display("tests_run %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Requests are held until taken; done means answer or idle again
	task op(input logic w, input logic [19:0] a, input logic [3:0] d);
		int n;
		n = 0;
		@(negedge clk);
		{req_valid, req_write, req_addr, req_wdata} = {1'h1, w, a, d};
		while (req_ready !== 1'h1 && n < 20)
		begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		req_valid = 1'h0;
		while ((w ? req_ready : rsp_valid) !== 1'h1 && n < 40)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 40)
			chk("handshake", 4'h1, 4'h0);
	endtask
	initial
	begin
		#50000;
		mismatches++;
		conclude();
	end
	initial
	begin
		repeat (4) @(negedge clk);
		nrst = 1'h1;
		foreach (rows[i])
		begin
			op(rows[i][24], rows[i][23:4], rows[i][3:0]);
			if (!rows[i][24])
				chk("rsp_rdata", rows[i][3:0], rsp_rdata);
		end
		$display("test table done");
		// Reset lands after take, before the strobe falls; wait out the turnaround first
		@(negedge clk);
		{req_valid, req_write, req_addr, req_wdata} = {1'h1, 1'h1, 20'hFFFFF, 4'h3};
		@(negedge clk);
		chk("write taken", 4'h2, {2'h0, wstrobe_n, data_oe_n});
		{req_valid, nrst} = 2'h0;
		#1;
		chk("idle pins", 4'hF, {sel_n, wstrobe_n, ogate_n, data_oe_n});
		chk("req_ready", 4'h1, {3'h0, req_ready});
		@(negedge clk);
		nrst = 1'h1;
		op(1'h0, 20'hFFFFF, 4'h0);
		chk("aborted write", 4'h5, rsp_rdata);
		$display("test reset abort done");
		conclude();
	end
endmodule
`default_nettype wire
